// [tx_fifo_defines.svh]
/*
  constants for the transmit fifo / demand dma block.
  assumes inclusion by bare name from the block's design file.
*/
`ifndef TX_FIFO_DEFINES_SVH
`define TX_FIFO_DEFINES_SVH
`define TXF_CAPACITY_BYTES 32'h0080_0000
`define TXF_LEVEL_W 24
`define TXF_PERIODIC_BITS 21
`define TXF_RATE_W 32
`define TXF_LEN_W 24
`define TXF_STAGE_DEPTH 4
`endif

// [tx_fifo_pkg.sv]
/*
  types shared by the transmit fifo / demand dma block.
  assumes the defines header is compiled alongside.
*/
`include "tx_fifo_defines.svh"
package tx_fifo_pkg;
  typedef enum logic [1:0] {ctl_stop, ctl_hold, ctl_send} transmit_control_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_type;
  typedef struct packed {
    logic start;
    logic [`TXF_LEN_W-1:0] length;
  } dma_cmd_type;
endpackage

// [tx_fifo_demand_dma.sv]
/*
  transmit buffering: staging fifo, demand-mode dma fetch, capacity-limited
  store, rate-paced drain and periodic / dma-done events.
  assumes read data arrives on the clk domain from a bus master that returns
  one byte per accepted request; the 27 MHz reference arrives as a pin.
*/
`include "tx_fifo_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tx_stage_fifo #(
  parameter int width = 8,
  parameter int depth = `TXF_STAGE_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem_ff [depth];
  logic [width-1:0] nxt_mem [depth];
  logic [aw-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [aw:0] cnt_ff, nxt_cnt;
  logic push, pop;

  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (push)
    begin
      nxt_mem[wp_ff] = in_data;
      nxt_wp = (wp_ff == aw'(depth - 1)) ? '0 : wp_ff + 1'b1;
    end
    if (pop)
      nxt_rp = (rp_ff == aw'(depth - 1)) ? '0 : rp_ff + 1'b1;
    nxt_cnt = cnt_ff + (aw+1)'(push) - (aw+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < depth; i++)
        mem_ff[i] <= '0;
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  assign in_ready = (cnt_ff != (aw+1)'(depth));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
endmodule

// Overview of operation
// RQ1: transmit buffer is a first-in first-out store of 8 megabytes.
// RQ2: buffer output removes bytes at the programmed constant rate to encoder.
// RQ3: software may lower the fill limit; largest setting is full capacity.
// RQ4: dma read requests are issued only while space remains below the limit.
// RQ5: fill level at or above the limit counts as full and stalls dma.
// RQ6: a stalled transfer resumes itself once level drops below the limit.
// RQ7: dma moves host data into the buffer with no per-byte host work.
// RQ8: host may also write the buffer directly, a slower alternative path.
// RQ9: periodic event fires once every 2^21 reference clock cycles.
// RQ10: rate generator uses a 32-bit value clocked from the same reference.
// RQ11: a transfer-complete event closes each dma transfer.
// RQ12: host preloads packets before starting transmission.
// RQ13: in hold, dma fills the buffer but nothing is sent.
// RQ14: transfer-complete only after the last byte is written, stalls included; code raises it once the last byte reaches the staging fifo.
module tx_fifo_demand_dma
  import tx_fifo_pkg::*;
#(
  parameter int level_w = `TXF_LEVEL_W,
  parameter logic [level_w:0] capacity = (level_w+1)'(`TXF_CAPACITY_BYTES),
  parameter int periodic_bits = `TXF_PERIODIC_BITS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ref_27m,
  input wire transmit_control_type transmit_control,
  input wire logic [level_w:0] size_limit,
  input wire logic [`TXF_RATE_W-1:0] tx_rate,
  input wire dma_cmd_type dma_cmd,
  output logic dma_busy,
  output logic dma_req,
  input wire byte_beat_type dma_rdata,
  input wire byte_beat_type host_wdata,
  output logic host_wready,
  output byte_beat_type enc_out,
  output logic [level_w:0] fill_level,
  output logic dma_done,
  output logic periodic_evt
);
  logic ref_s1_ff, ref_s2_ff, ref_s3_ff;
  logic [periodic_bits-1:0] per_cnt_ff, nxt_per_cnt;
  logic [`TXF_RATE_W-1:0] acc_ff, nxt_acc;
  logic [`TXF_LEN_W-1:0] remain_ff, nxt_remain;
  logic [level_w:0] level_ff, nxt_level, lim;
  logic [level_w-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [7:0] store [2**level_w];
  logic busy_ff, nxt_busy, req_ff, nxt_req, done_ff, nxt_done, per_ff, nxt_per;
  byte_beat_type enc_ff, nxt_enc;
  logic [7:0] st_data;
  logic st_valid, st_ready, in_valid, in_ready, room, ref_rise, tick, wr, rd;

  // limit saturates at capacity; a zero limit passes through, leaves no room and stalls dma
  assign lim = (size_limit > capacity) ? capacity : size_limit; // RQ3
  assign room = level_ff < lim; // RQ5

  // dma data wins the staging port; the host path waits when dma is busy
  assign in_valid = dma_rdata.valid || (!busy_ff && host_wdata.valid); // RQ8

  tx_stage_fifo #(.width(8), .depth(`TXF_STAGE_DEPTH)) u_stage (
    .clk(clk),
    .rstn(rstn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(dma_rdata.valid ? dma_rdata.data : host_wdata.data),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data(st_data)
  );

  assign st_ready = room; // RQ6
  assign wr = st_valid && st_ready;
  assign ref_rise = ref_s2_ff && !ref_s3_ff;
  // rate accumulator on reference edges, carry marks one byte slot
  assign tick = ref_rise && ({1'b0, acc_ff} + {1'b0, tx_rate}) >>
    `TXF_RATE_W != 0; // RQ10
  assign rd = tick && transmit_control == ctl_send && level_ff != '0; // RQ2 RQ13

  always_comb
  begin
    nxt_per_cnt = per_cnt_ff + (ref_rise ? 1'b1 : 1'b0);
    nxt_per = ref_rise && (per_cnt_ff == '1); // RQ9
    nxt_acc = ref_rise ? acc_ff + tx_rate : acc_ff;
    nxt_level = level_ff + (level_w+1)'(wr) - (level_w+1)'(rd); // RQ1
    nxt_wp = wp_ff + level_w'(wr);
    nxt_rp = rp_ff + level_w'(rd);
    nxt_enc.valid = rd;
    nxt_enc.data = rd ? store[rp_ff] : enc_ff.data;
    nxt_busy = busy_ff;
    nxt_remain = remain_ff;
    nxt_done = 1'b0;
    // request re-pulses every other cycle until a byte returns; staging fifo absorbs the returned byte
    nxt_req = 1'b0;
    if (!busy_ff && dma_cmd.start && dma_cmd.length != '0)
    begin
      nxt_busy = 1'b1;
      nxt_remain = dma_cmd.length;
    end
    else if (busy_ff)
    begin
      if (dma_rdata.valid)
        nxt_remain = remain_ff - 1'b1;
      if (dma_rdata.valid && remain_ff == `TXF_LEN_W'(1))
      begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1; // RQ11 RQ14
      end
      // request only with space below the limit and staging empty
      nxt_req = room && !st_valid && !req_ff && !dma_rdata.valid &&
        remain_ff != '0; // RQ4 RQ7
    end
  end

  always_ff @(posedge clk)
    if (wr)
      store[wp_ff] <= st_data;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
      per_cnt_ff <= '0;
      per_ff <= 1'b0;
      acc_ff <= '0;
      level_ff <= '0;
      wp_ff <= '0;
      rp_ff <= '0;
      enc_ff <= '0;
      busy_ff <= 1'b0;
      remain_ff <= '0;
      done_ff <= 1'b0;
      req_ff <= 1'b0;
    end
    else
    begin
      ref_s1_ff <= ref_27m;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
      per_cnt_ff <= nxt_per_cnt;
      per_ff <= nxt_per;
      acc_ff <= nxt_acc;
      level_ff <= nxt_level;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      enc_ff <= nxt_enc;
      busy_ff <= nxt_busy;
      remain_ff <= nxt_remain;
      done_ff <= nxt_done;
      req_ff <= nxt_req;
    end
  end

  assign dma_busy = busy_ff;
  assign dma_req = req_ff;
  assign host_wready = in_ready && !busy_ff;
  assign enc_out = enc_ff;
  assign fill_level = level_ff;
  assign dma_done = done_ff;
  assign periodic_evt = per_ff;

  AST_NO_OVERFILL: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    level_ff >= lim |=> !($past(wr)) || level_ff <= $past(level_ff))
    else $error("buffer written while at limit");
  AST_REQ_ROOM: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    req_ff |-> $past(room))
    else $error("dma request without room");
  AST_HOLD_SILENT: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    transmit_control != ctl_send |=> !enc_ff.valid)
    else $error("byte sent outside send state");
  AST_DONE_LAST: assert property (@(posedge clk) disable iff (!rstn) // RQ14
    done_ff |-> $past(dma_rdata.valid) && remain_ff == '0 && !busy_ff)
    else $error("done before last byte");
  AST_DONE_ONCE: assert property (@(posedge clk) disable iff (!rstn) // RQ11
    done_ff |=> !done_ff)
    else $error("done longer than one cycle");
  AST_PERIODIC: assert property (@(posedge clk) disable iff (!rstn) // RQ9
    per_ff |-> per_cnt_ff == '0 && $past(ref_rise))
    else $error("periodic event off its count");
  AST_DRAIN_RATE: assert property (@(posedge clk) disable iff (!rstn) // RQ2
    enc_ff.valid |-> $past(ref_rise))
    else $error("byte sent off a rate slot");
  AST_LEVEL_BOUND: assert property (@(posedge clk) disable iff (!rstn) // RQ1
    level_ff <= capacity)
    else $error("fill level above capacity");
endmodule

`default_nettype wire

// [host_mem_model.sv]
/*
  host memory model answering dma byte requests, promptly or slowly.
  assumes at most one request outstanding at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module host_mem_model
  import tx_fifo_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic dma_req,
  input wire logic slow,
  output byte_beat_type dma_rdata,
  output int served
);
  initial
  begin
    dma_rdata = '0;
    served = 0;
  end
  // data is served from a counter so the bench can predict it
  always @(posedge clk)
    if (rstn && dma_req)
    begin
      repeat (slow ? $urandom % 4 : 0) @(posedge clk);
      #1 dma_rdata = '{1'b1, 8'(served) ^ 8'h5a};
      @(posedge clk);
      // released data line shows the inverse, not the stale byte
      #1 dma_rdata = '{1'b0, ~dma_rdata.data};
      served++;
    end
endmodule
`default_nettype wire

// [tb_tx_fifo_demand_dma.sv]
/*
  self-checking bench for the transmit fifo with demand dma.
  assumes the host memory model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_tx_fifo_demand_dma;
  import tx_fifo_pkg::*;
  logic clk = 0, rstn = 0, ref_27m = 0, slow = 0;
  transmit_control_type ctl = ctl_hold;
  logic [6:0] lim = 7'd10, lvl;
  dma_cmd_type cmd = '0;
  byte_beat_type hw = '0, rd, enc;
  logic busy, req, hrdy, done, pev;
  logic [2:0] rs = '0;
  logic [7:0] exp_q[$];
  int served, fail_count = 0, n_compared = 0, cyc = 0;
  int total = 0, rises = 0, last_rise = -1;
  always #2.5 clk = ~clk;
  // offset keeps reference edges off clock edges, so sampling never races
  initial
  begin
    #1.25;
    forever #18.5 ref_27m = ~ref_27m;
  end
  tx_fifo_demand_dma #(.level_w(6), .capacity(7'd64), .periodic_bits(4))
    dut_u (.clk(clk), .rstn(rstn), .ref_27m(ref_27m),
    .transmit_control(ctl), .size_limit(lim), .tx_rate(32'h4000_0000),
    .dma_cmd(cmd), .dma_busy(busy), .dma_req(req), .dma_rdata(rd),
    .host_wdata(hw), .host_wready(hrdy), .enc_out(enc),
    .fill_level(lvl), .dma_done(done), .periodic_evt(pev));
  host_mem_model mem_u (.clk(clk), .rstn(rstn), .dma_req(req),
    .slow(slow), .dma_rdata(rd), .served(served));
  task report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task dma(input int len);
    @(negedge clk);
    cmd = '{1'b1, 24'(len)};
    @(negedge clk);
    cmd.start = 1'b0;
  endtask
  task push_dma(input int len);
    for (int i = 0; i < len; i++)
      exp_q.push_back(8'(total + i) ^ 8'h5a);
    total += len;
  endtask
  always @(posedge clk)
    if (rstn)
    begin
      cyc++;
      if (cyc > 20000)
      begin
        bad("timeout");
        report_and_stop();
      end
      if (enc.valid === 1'b1)
      begin
        n_compared++;
        if (exp_q.size() == 0 || enc.data !== exp_q.pop_front())
          bad("output byte wrong");
      end
      n_compared++;
      if ((lvl <= lim) !== 1'b1)
        bad("level above limit");
      if (ctl == ctl_hold && enc.valid === 1'b1)
        bad("sent while held");
      if (done === 1'b1)
      begin
        n_compared++;
        if (served != total)
          bad("done before last byte");
      end
      if (pev === 1'b1)
      begin
        n_compared++;
        if (last_rise >= 0 && rises - last_rise != 16)
          bad("periodic spacing");
        last_rise = rises;
      end
      // same two-stage sampling as the design keeps the count phase-exact
      if (rs[1] && !rs[2])
        rises++;
      rs = {rs[1:0], ref_27m};
    end
  initial
  begin
    void'($urandom(32'hf8d3d03c));
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    push_dma(20);
    dma(20);
    repeat (300) @(negedge clk);
    n_compared++;
    if (lvl !== 7'd10 || busy !== 1'b1)
      bad("dma not stalled at limit");
    dma(5);
    ctl = ctl_send;
    lim = 7'd64;
    slow = 1'b1;
    while (busy !== 1'b0)
      @(negedge clk);
    for (int i = 0; i < 3; i++)
    begin
      while (hrdy !== 1'b1)
        @(negedge clk);
      hw = '{1'b1, 8'($urandom)};
      exp_q.push_back(hw.data);
      @(negedge clk);
      hw.valid = 1'b0;
    end
    push_dma(3);
    dma(3);
    while (busy !== 1'b0 || exp_q.size() != 0)
      @(negedge clk);
    repeat (300) @(negedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
